// ===== hdl/ucbt_pkg.sv
// Package of register offsets, field positions and reset values for the serial port control block
package ucbt_pkg;
   // ==========================================================
   // Bus widths
   localparam int ADDR_W = 12;
   localparam int DATA_W = 8;

   // ==========================================================
   // Register offsets
   localparam logic [11:0] OFF_DATA_PORT0   = 12'hF40;
   localparam logic [11:0] OFF_DATA_PORT1   = 12'hF48;
   localparam logic [11:0] OFF_CTRL0        = 12'hF41;
   localparam logic [11:0] OFF_CTRL1        = 12'hF42;
   localparam logic [11:0] OFF_ADDR_CMP     = 12'hF43;
   localparam logic [11:0] OFF_BAUD_HI      = 12'hF44;
   localparam logic [11:0] OFF_BAUD_LO      = 12'hF45;
   localparam logic [11:0] OFF_IRQ_STATUS   = 12'hF46;
   localparam logic [11:0] OFF_IRQ_MASK     = 12'hF47;

   // ==========================================================
   // Control 0 fields
   localparam int C0_TX_ON      = 7;
   localparam int C0_RX_ON      = 6;
   localparam int C0_DRV_POL    = 5;
   localparam int C0_NINTH_EN   = 4;
   localparam int C0_NINTH_VAL  = 3;

   // ==========================================================
   // Control 1 fields
   localparam int C1_MP_SEL_LO  = 0;
   localparam int C1_BAUD_TMR   = 2;
   localparam int C1_RX_IRQ_MSK = 3;
   localparam int C1_IR_EN      = 4;

   // ==========================================================
   // Status bits
   localparam int ST_RX         = 0;
   localparam int ST_RX_ERR     = 1;
   localparam int ST_TIMER      = 2;
   localparam int ST_TX_DONE    = 3;

   // ==========================================================
   // Reset values
   localparam logic [7:0]  RST_CTRL0    = 8'h00;
   localparam logic [7:0]  RST_CTRL1    = 8'h00;
   localparam logic [7:0]  RST_ADDR_CMP = 8'h00;
   localparam logic [15:0] RST_BAUD     = 16'h0002;
   localparam logic [7:0]  RST_MASK     = 8'h00;

   // ==========================================================
   // Timing
   localparam int OVERSAMPLE = 16;
   localparam logic [3:0] OVS_LAST = 4'hF;
   localparam logic [3:0] OVS_MID  = 4'h7;
endpackage

// ===== hdl/ucbt_top.sv
// Serial port control, transmit path, multidrop receive filter and baud timer
// Operation
// [RQ1] Timer mode interrupts every clock period times the 16-bit divisor.
// [RQ2] Writes to the shared data offset transmit; reads return received data.
// [RQ3] Selection 01 interrupts only on received address bytes.
// [RQ4] Selection 10 interrupts on matching address and following data until mismatch.
// [RQ5] Selection 11 interrupts on data bytes after a matching address only.
// [RQ6] Ninth-bit framing only while ninth-bit mode enable is one.
// [RQ7] In ninth-bit mode the transmitter sends the ninth-bit value.
// [RQ8] Driver enable is active high at polarity zero, low at one.
// [RQ9] Receiver off, timer control one: interrupt at zero, reads show count.
// [RQ10] Timer control zero: baud reads return the reload value.
// [RQ11] Receiver on, timer control one: reads show count, no timer interrupt.
// [RQ12] Low byte read does not latch the high byte.
// [RQ13] Receive mask zero: data and errors interrupt; one: errors only.
// [RQ14] Infrared codec disabled passes ordinary serial frames.
// [RQ15] Bit rate is clock divided by sixteen times the divisor.
// [RQ16] Software disables transmitter and receiver before loading and starting the timer.
// [RQ17] Timer reloads from the divisor at zero and keeps counting.
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/10ps
module ucbt_top
   import ucbt_pkg::*;
(
   // Clock and reset
   input  wire logic                       clk,
   input  wire logic                       rst_n,
   // Register port
   input  wire logic [ucbt_pkg::ADDR_W-1:0] reg_addr,
   input  wire logic [ucbt_pkg::DATA_W-1:0] reg_wdata,
   input  wire logic                       reg_wr,
   input  wire logic                       reg_rd,
   output logic      [ucbt_pkg::DATA_W-1:0] reg_rdata,
   // Serial pins
   input  wire logic                       serial_in_pin,
   output logic                            serial_out_pin,
   output logic                            line_driver_on,
   // Interrupt
   output logic                            irq
);
   import ucbt_pkg::*;

   // ==========================================================
   // Registers
   logic [7:0]  ctrl0_reg, ctrl1_reg, addr_cmp_reg, status_reg, mask_reg;
   logic [15:0] baud_divisor_count_reg, baud_cnt_reg;
   logic [7:0]  rx_data_reg;
   logic [7:0]  transmit_holding_reg;
   logic        tx_pend_reg;

   wire transmitter_on        = ctrl0_reg[C0_TX_ON];
   wire receiver_on           = ctrl0_reg[C0_RX_ON];
   wire driver_enable_polarity = ctrl0_reg[C0_DRV_POL];
   wire ninth_bit_mode_enable = ctrl0_reg[C0_NINTH_EN];
   wire ninth_bit_value       = ctrl0_reg[C0_NINTH_VAL];
   wire [1:0] mp_sel          = ctrl1_reg[C1_MP_SEL_LO +: 2];
   wire baud_timer_control    = ctrl1_reg[C1_BAUD_TMR];
   wire receive_data_irq_mask = ctrl1_reg[C1_RX_IRQ_MSK];
   wire infrared_codec_enable = ctrl1_reg[C1_IR_EN];

   // ==========================================================
   // Decode
   wire sel_data  = (reg_addr == OFF_DATA_PORT0) || (reg_addr == OFF_DATA_PORT1);
   wire wr_data   = reg_wr && sel_data;
   wire wr_ctrl0  = reg_wr && (reg_addr == OFF_CTRL0);
   wire wr_ctrl1  = reg_wr && (reg_addr == OFF_CTRL1);
   wire wr_cmp    = reg_wr && (reg_addr == OFF_ADDR_CMP);
   wire wr_bhi    = reg_wr && (reg_addr == OFF_BAUD_HI);
   wire wr_blo    = reg_wr && (reg_addr == OFF_BAUD_LO);
   wire wr_stat   = reg_wr && (reg_addr == OFF_IRQ_STATUS);
   wire wr_mask   = reg_wr && (reg_addr == OFF_IRQ_MASK);

   // ==========================================================
   // Baud generator: one tick per divisor period, 16 ticks per bit
   wire        baud_zero  = (baud_cnt_reg <= 16'h0001);
   wire        baud_tick  = baud_zero;
   wire [15:0] div_next   = {wr_bhi ? reg_wdata : baud_divisor_count_reg[15:8],
                             wr_blo ? reg_wdata : baud_divisor_count_reg[7:0]};
   // Live count or reload for readback, sampled at each byte's own read
   wire [15:0] baud_view  = baud_timer_control ? baud_cnt_reg : baud_divisor_count_reg; // see [RQ10] see [RQ11]

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         baud_cnt_reg <= RST_BAUD;
      end else if (wr_bhi || wr_blo || baud_zero) begin
         baud_cnt_reg <= div_next; // see [RQ17] see [RQ15]
      end else begin
         baud_cnt_reg <= baud_cnt_reg - 16'h0001;
      end
   end

   // Timer event only with receiver off
   wire timer_evt = baud_zero && baud_timer_control && !receiver_on; // see [RQ1] see [RQ9] see [RQ11]

   // ==========================================================
   // Transmitter
   typedef enum logic [1:0] {UCBT_TX_IDLE, UCBT_TX_START, UCBT_TX_BITS, UCBT_TX_STOP} ucbt_tx_t;
   ucbt_tx_t    tx_state_reg;
   logic [3:0]  tx_ovs_reg;
   logic [3:0]  tx_idx_reg;
   logic [8:0]  tx_shift_reg;
   logic        tx_done;
   wire  [3:0]  tx_nbits = ninth_bit_mode_enable ? 4'h9 : 4'h8; // see [RQ6]
   wire         tx_bit_end = baud_tick && (tx_ovs_reg == OVS_LAST);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         transmit_holding_reg <= 8'h00;
         tx_pend_reg          <= 1'b0;
      end else if (wr_data) begin
         transmit_holding_reg <= reg_wdata; // see [RQ2]
         tx_pend_reg          <= 1'b1;
      end else if (tx_state_reg == UCBT_TX_IDLE && transmitter_on && tx_pend_reg) begin
         tx_pend_reg          <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_state_reg <= UCBT_TX_IDLE;
         tx_ovs_reg   <= 4'h0;
         tx_idx_reg   <= 4'h0;
         tx_shift_reg <= 9'h1FF;
      end else begin
         if (baud_tick && tx_state_reg != UCBT_TX_IDLE) begin
            tx_ovs_reg <= tx_ovs_reg + 4'h1;
         end
         case (tx_state_reg)
            UCBT_TX_IDLE: begin
               tx_ovs_reg <= 4'h0;
               if (transmitter_on && tx_pend_reg && !wr_data) begin
                  // Ninth bit carries the value control; it is sent only in ninth-bit mode
                  tx_shift_reg <= {ninth_bit_value, transmit_holding_reg}; // see [RQ7]
                  tx_state_reg <= UCBT_TX_START;
               end
            end
            UCBT_TX_START: begin
               if (tx_bit_end) begin
                  tx_idx_reg   <= 4'h0;
                  tx_state_reg <= UCBT_TX_BITS;
               end
            end
            UCBT_TX_BITS: begin
               if (tx_bit_end) begin
                  tx_shift_reg <= {1'b1, tx_shift_reg[8:1]};
                  tx_idx_reg   <= tx_idx_reg + 4'h1;
                  if (tx_idx_reg == tx_nbits - 4'h1) begin
                     tx_state_reg <= UCBT_TX_STOP;
                  end
               end
            end
            UCBT_TX_STOP: begin
               if (tx_bit_end) begin
                  tx_state_reg <= UCBT_TX_IDLE;
               end
            end
            default: tx_state_reg <= UCBT_TX_IDLE;
         endcase
      end
   end

   assign tx_done = (tx_state_reg == UCBT_TX_STOP) && tx_bit_end;

   // Raw line before the optional infrared pulse shaping
   wire tx_line = (tx_state_reg == UCBT_TX_START) ? 1'b0 :
                  (tx_state_reg == UCBT_TX_BITS)  ? tx_shift_reg[0] : 1'b1;
   // Infrared: short high pulse for each zero bit, in the first quarter of the bit
   wire ir_tx   = !tx_line && (tx_ovs_reg < 4'h4);
   wire tx_pin  = infrared_codec_enable ? ir_tx : tx_line; // see [RQ14]
   wire drv_act = (tx_state_reg != UCBT_TX_IDLE);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         serial_out_pin <= 1'b1;
         line_driver_on <= 1'b0;
      end else begin
         serial_out_pin <= tx_pin;
         line_driver_on <= drv_act ^ driver_enable_polarity; // see [RQ8]
      end
   end

   // ==========================================================
   // Receiver
   logic rx_meta_reg, rx_sync_reg;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_meta_reg <= 1'b1;
         rx_sync_reg <= 1'b1;
      end else begin
         rx_meta_reg <= serial_in_pin;
         rx_sync_reg <= rx_meta_reg;
      end
   end
   // Infrared decoder: the synchronised line is only inverted, so a high level at the mid-bit sample means a zero bit
   wire rx_line = infrared_codec_enable ? !rx_sync_reg : rx_sync_reg; // see [RQ14]

   typedef enum logic [1:0] {UCBT_RX_IDLE, UCBT_RX_START, UCBT_RX_BITS, UCBT_RX_STOP} ucbt_rx_t;
   ucbt_rx_t   rx_state_reg;
   logic [3:0] rx_ovs_reg, rx_idx_reg;
   logic [8:0] rx_shift_reg;
   logic       addr_hit_reg;
   logic       rx_evt, rx_err_evt;
   wire        rx_mid = baud_tick && (rx_ovs_reg == OVS_MID);
   wire        rx_is_addr = rx_shift_reg[8];
   wire        rx_match   = (rx_shift_reg[7:0] == addr_cmp_reg);
   wire        rx_frame_end = (rx_state_reg == UCBT_RX_STOP) && rx_mid;
   wire [3:0]  rx_nbits = ninth_bit_mode_enable ? 4'h9 : 4'h8; // see [RQ6]

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_state_reg <= UCBT_RX_IDLE;
         rx_ovs_reg   <= 4'h0;
         rx_idx_reg   <= 4'h0;
         rx_shift_reg <= 9'h000;
      end else begin
         if (baud_tick) begin
            rx_ovs_reg <= rx_ovs_reg + 4'h1;
         end
         case (rx_state_reg)
            UCBT_RX_IDLE: begin
               rx_ovs_reg <= 4'h0;
               if (receiver_on && !rx_line) begin
                  rx_state_reg <= UCBT_RX_START;
               end
            end
            UCBT_RX_START: begin
               if (rx_mid) begin
                  rx_idx_reg   <= 4'h0;
                  rx_state_reg <= rx_line ? UCBT_RX_IDLE : UCBT_RX_BITS;
               end
            end
            UCBT_RX_BITS: begin
               if (rx_mid) begin
                  // Eight-bit frames leave bit 8 clear
                  rx_shift_reg <= ninth_bit_mode_enable ? {rx_line, rx_shift_reg[8:1]}
                                                        : {1'b0, rx_line, rx_shift_reg[7:1]};
                  rx_idx_reg   <= rx_idx_reg + 4'h1;
                  if (rx_idx_reg == rx_nbits - 4'h1) begin
                     rx_state_reg <= UCBT_RX_STOP;
                  end
               end
            end
            UCBT_RX_STOP: begin
               if (rx_mid) begin
                  rx_state_reg <= UCBT_RX_IDLE;
               end
            end
            default: rx_state_reg <= UCBT_RX_IDLE;
         endcase
      end
   end

   // Multidrop filter
   logic rx_want;
   always_comb begin
      rx_want = 1'b1;
      if (ninth_bit_mode_enable) begin
         case (mp_sel)
            2'b01:   rx_want = rx_is_addr; // see [RQ3]
            2'b10:   rx_want = rx_is_addr ? rx_match : addr_hit_reg; // see [RQ4]
            2'b11:   rx_want = !rx_is_addr && addr_hit_reg; // see [RQ5]
            default: rx_want = 1'b1;
         endcase
      end
   end

   assign rx_err_evt = rx_frame_end && !rx_line;
   assign rx_evt     = rx_frame_end && rx_line && rx_want && !receive_data_irq_mask; // see [RQ13]

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         addr_hit_reg <= 1'b0;
         rx_data_reg  <= 8'h00;
      end else if (rx_frame_end) begin
         rx_data_reg <= rx_shift_reg[7:0];
         if (rx_is_addr) begin
            addr_hit_reg <= rx_match;
         end
      end
   end

   // ==========================================================
   // Control registers and interrupt status
   wire [7:0] evt_vec = {4'h0, tx_done, timer_evt, rx_err_evt, rx_evt};
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl0_reg              <= RST_CTRL0;
         ctrl1_reg              <= RST_CTRL1;
         addr_cmp_reg           <= RST_ADDR_CMP;
         baud_divisor_count_reg <= RST_BAUD;
         mask_reg               <= RST_MASK;
         status_reg             <= 8'h00;
      end else begin
         if (wr_ctrl0) ctrl0_reg <= reg_wdata;
         if (wr_ctrl1) ctrl1_reg <= reg_wdata;
         if (wr_cmp)   addr_cmp_reg <= reg_wdata;
         if (wr_bhi)   baud_divisor_count_reg[15:8] <= reg_wdata;
         if (wr_blo)   baud_divisor_count_reg[7:0]  <= reg_wdata;
         if (wr_mask)  mask_reg <= reg_wdata;
         // A new event wins over a same-cycle clear
         status_reg <= (status_reg & ~(wr_stat ? reg_wdata : 8'h00)) | evt_vec;
      end
   end

   // ==========================================================
   // Read data, one cycle after the strobe
   wire [7:0] rd_mux =
      sel_data                      ? rx_data_reg :
      (reg_addr == OFF_CTRL0)       ? ctrl0_reg :
      (reg_addr == OFF_CTRL1)       ? ctrl1_reg :
      (reg_addr == OFF_ADDR_CMP)    ? addr_cmp_reg :
      (reg_addr == OFF_BAUD_HI)     ? baud_view[15:8] : // see [RQ12]
      (reg_addr == OFF_BAUD_LO)     ? baud_view[7:0] :
      (reg_addr == OFF_IRQ_STATUS)  ? status_reg :
      (reg_addr == OFF_IRQ_MASK)    ? mask_reg : 8'h00;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
         irq       <= 1'b0;
      end else begin
         reg_rdata <= reg_rd ? rd_mux : 8'h00;
         irq       <= |(status_reg & mask_reg);
      end
   end

   // ==========================================================
   // Checks
   property p_timer_period;
      @(posedge clk) disable iff (!rst_n)
      timer_evt |=> !timer_evt || (baud_divisor_count_reg <= 16'h0001);
   endproperty
   a_timer_period: assert property (p_timer_period) else $error("timer event twice in a row"); // see [RQ1]

   property p_timer_rx_off;
      @(posedge clk) disable iff (!rst_n)
      receiver_on |=> !$rose(status_reg[ST_TIMER]);
   endproperty
   a_timer_rx_off: assert property (p_timer_rx_off) else $error("timer event while not allowed"); // see [RQ11]

   property p_reload_read;
      @(posedge clk) disable iff (!rst_n)
      reg_rd && reg_addr == OFF_BAUD_LO && !baud_timer_control |=> reg_rdata == $past(baud_divisor_count_reg[7:0]);
   endproperty
   a_reload_read: assert property (p_reload_read) else $error("baud read not reload"); // see [RQ10]

   property p_live_read;
      @(posedge clk) disable iff (!rst_n)
      reg_rd && reg_addr == OFF_BAUD_HI && baud_timer_control |=> reg_rdata == $past(baud_cnt_reg[15:8]);
   endproperty
   a_live_read: assert property (p_live_read) else $error("baud read not live"); // see [RQ9]

   property p_drv_pol;
      @(posedge clk) disable iff (!rst_n)
      ##1 $stable(driver_enable_polarity) |-> line_driver_on == ($past(drv_act) ^ driver_enable_polarity);
   endproperty
   a_drv_pol: assert property (p_drv_pol) else $error("driver enable polarity wrong"); // see [RQ8]

   property p_mask_data;
      @(posedge clk) disable iff (!rst_n)
      receive_data_irq_mask |=> !$rose(status_reg[ST_RX]);
   endproperty
   a_mask_data: assert property (p_mask_data) else $error("masked data interrupt"); // see [RQ13]

   property p_sel11_addr;
      @(posedge clk) disable iff (!rst_n)
      rx_frame_end && rx_is_addr && ninth_bit_mode_enable && mp_sel == 2'b11 |=> !$rose(status_reg[ST_RX]);
   endproperty
   a_sel11_addr: assert property (p_sel11_addr) else $error("address byte interrupt in select 11"); // see [RQ5]

   property p_sel01;
      @(posedge clk) disable iff (!rst_n)
      rx_frame_end && !rx_is_addr && ninth_bit_mode_enable && mp_sel == 2'b01 |=> !$rose(status_reg[ST_RX]);
   endproperty
   a_sel01: assert property (p_sel01) else $error("data byte interrupt in select 01"); // see [RQ3]

   sequence s_start_bit;
      tx_state_reg == UCBT_TX_IDLE ##1 tx_state_reg == UCBT_TX_START;
   endsequence
   property p_tx_start;
      @(posedge clk) disable iff (!rst_n)
      s_start_bit |=> serial_out_pin == infrared_codec_enable;
   endproperty
   a_tx_start: assert property (p_tx_start) else $error("start bit not driven"); // see [RQ2] see [RQ14]
endmodule

// ===== dv/ucbt_remote_node.sv
// Remote serial node that sends frames to the port and receives frames from it
`timescale 1ns/10ps
module ucbt_remote_node #(
   parameter int BIT_CLKS = 16
) (
   // Clock
   input  wire logic clk,
   // Serial lines
   input  wire logic from_dut,
   input  wire logic drv_on,
   output logic      to_dut
);
   // Line idles at the marking level between frames
   initial to_dut = 1'b1;

   // ==========================================================
   // Frame sender, stop level selectable to force a framing error
   task automatic send(input logic [8:0] val, input int nbits, input logic stop);
      @(posedge clk);
      to_dut <= 1'b0;
      repeat (BIT_CLKS) @(posedge clk);
      for (int i = 0; i < nbits; i++) begin
         to_dut <= val[i];
         repeat (BIT_CLKS) @(posedge clk);
      end
      to_dut <= stop;
      repeat (BIT_CLKS) @(posedge clk);
      to_dut <= 1'b1;
      repeat (2 * BIT_CLKS) @(posedge clk);
   endtask

   // ==========================================================
   // Frame receiver, samples each bit in its middle
   task automatic recv(input int nbits, output logic [8:0] val, output logic de, output logic stp);
      int n;
      n = 0;
      val = 9'h000;
      while (from_dut !== 1'b0 && n < 4000) begin
         @(posedge clk);
         n++;
      end
      repeat (BIT_CLKS / 2) @(posedge clk);
      de = drv_on;
      for (int i = 0; i < nbits; i++) begin
         repeat (BIT_CLKS) @(posedge clk);
         val[i] = from_dut;
      end
      repeat (BIT_CLKS) @(posedge clk);
      stp = from_dut;
   endtask
endmodule

// ===== dv/test_uart_control_and_baud_timer.sv
// Self-checking bench for the serial port control and baud timer block
`timescale 1ns/10ps
module test_uart_control_and_baud_timer;
   import ucbt_pkg::*;
   // ==========================================================
   // Signals
   logic              clk;
   logic              rst_n;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata;
   logic              reg_wr;
   logic              reg_rd;
   logic [DATA_W-1:0] reg_rdata;
   logic              serial_in_pin;
   logic              serial_out_pin;
   logic              line_driver_on;
   logic              irq;
   int                err_count;
   int                num_checks;
   int                cyc = 0;

   ucbt_top i_dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .serial_in_pin(serial_in_pin),
      .serial_out_pin(serial_out_pin), .line_driver_on(line_driver_on), .irq(irq));
   ucbt_remote_node i_node (.clk(clk), .from_dut(serial_out_pin), .drv_on(line_driver_on),
      .to_dut(serial_in_pin));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) cyc <= cyc + 1;

   // ==========================================================
   // Shared tasks
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   function automatic logic [15:0] x1(input logic b);
      return {15'h0000, b};
   endfunction
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr    <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd   <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic rdchk(input string what, input logic [11:0] a, input logic [7:0] exp);
      logic [7:0] d;
      rd(a, d);
      chk(what, {8'h00, exp}, {8'h00, d});
   endtask
   task automatic wait_irq(input logic lvl);
      int n;
      n = 0;
      while (irq !== lvl && n < 2000) begin
         @(posedge clk);
         #1 n++;
      end
      chk("irq level", x1(lvl), x1(irq));
   endtask
   task automatic close_out();
      if (err_count == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_reset();
      rdchk("baud hi", OFF_BAUD_HI, 8'h00);
      rdchk("baud lo", OFF_BAUD_LO, 8'h02);
      rdchk("unmapped", 12'h123, 8'h00);
      chk("driver idle", x1(1'b0), x1(line_driver_on));
      wr(OFF_BAUD_LO, 8'h01);
   endtask
   task automatic t_tx(input logic pol, en, val, input logic [11:0] a, input logic [7:0] d);
      logic [8:0] got;
      logic       de;
      logic       stp;
      wr(OFF_CTRL0, {2'b10, pol, en, val, 3'b000});
      wr(a, d);
      i_node.recv(en ? 9 : 8, got, de, stp);
      chk("tx frame", {7'h00, en & val, d}, {7'h00, got});
      chk("driver on", x1(~pol), x1(de));
      chk("stop bit", x1(1'b1), x1(stp));
      repeat (16) @(posedge clk);
      #1 chk("driver off", x1(pol), x1(line_driver_on));
   endtask
   task automatic t_ir();
      int n;
      n = 0;
      wr(OFF_CTRL1, 8'h10);
      wr(OFF_CTRL0, 8'h80);
      wr(OFF_DATA_PORT0, 8'h00);
      while (serial_out_pin !== 1'b1 && n < 100) begin
         @(posedge clk);
         n++;
      end
      n = 0;
      while (serial_out_pin === 1'b1 && n < 100) begin
         @(posedge clk);
         n++;
      end
      chk("ir start pulse", 16'h0004, 16'(n));
      repeat (200) @(posedge clk);
      wr(OFF_CTRL1, 8'h00);
   endtask
   task automatic t_rx();
      wr(OFF_CTRL0, 8'h40);
      wr(OFF_IRQ_MASK, 8'h03);
      wr(OFF_IRQ_STATUS, 8'hFF);
      i_node.send(9'h096, 8, 1'b1);
      chk("rx irq", x1(1'b1), x1(irq));
      rdchk("rx data", OFF_DATA_PORT0, 8'h96);
      wr(OFF_IRQ_STATUS, 8'hFF);
      wr(OFF_CTRL1, 8'h08);
      i_node.send(9'h055, 8, 1'b1);
      chk("rx masked irq", x1(1'b0), x1(irq));
      i_node.send(9'h055, 8, 1'b0);
      chk("rx error irq", x1(1'b1), x1(irq));
   endtask
   task automatic t_multi(input logic [1:0] sel, input logic [3:0] exp);
      logic [8:0] fr [4];
      logic [7:0] st;
      fr = '{9'h13C, 9'h0A1, 9'h111, 9'h0B2};
      wr(OFF_CTRL0, 8'h50);
      wr(OFF_CTRL1, {6'h00, sel});
      wr(OFF_ADDR_CMP, 8'h3C);
      for (int i = 0; i < 4; i++) begin
         wr(OFF_IRQ_STATUS, 8'hFF);
         i_node.send(fr[i], 9, 1'b1);
         rd(OFF_IRQ_STATUS, st);
         chk("multidrop event", x1(exp[3-i]), x1(st[ST_RX]));
      end
   endtask
   task automatic t_timer();
      int         t0;
      logic [7:0] a;
      logic [7:0] b;
      wr(OFF_CTRL0, 8'h00);
      wr(OFF_BAUD_LO, 8'h28);
      wr(OFF_CTRL1, 8'h04);
      wr(OFF_IRQ_MASK, 8'h04);
      wr(OFF_IRQ_STATUS, 8'hFF);
      wait_irq(1'b1);
      t0 = cyc;
      wr(OFF_IRQ_STATUS, 8'h04);
      wait_irq(1'b0);
      wait_irq(1'b1);
      chk("timer period", 16'h0028, 16'(cyc - t0));
      rd(OFF_BAUD_LO, a);
      rd(OFF_BAUD_LO, b);
      chk("live count step", 16'h0002, {8'h00, a - b});
      rdchk("live count hi", OFF_BAUD_HI, 8'h00);
      wr(OFF_IRQ_MASK, 8'h00);
      wr(OFF_IRQ_STATUS, 8'hFF);
      repeat (50) @(posedge clk);
      #1 chk("masked timer irq", x1(1'b0), x1(irq));
      rdchk("timer status", OFF_IRQ_STATUS, 8'h04);
      wr(OFF_CTRL0, 8'h40);
      wr(OFF_IRQ_STATUS, 8'hFF);
      repeat (100) @(posedge clk);
      rdchk("rx on status", OFF_IRQ_STATUS, 8'h00);
      rd(OFF_BAUD_LO, a);
      rd(OFF_BAUD_LO, b);
      chk("rx on count step", 16'h0002, {8'h00, a - b});
      wr(OFF_CTRL1, 8'h00);
      rdchk("reload lo", OFF_BAUD_LO, 8'h28);
      rdchk("reload lo again", OFF_BAUD_LO, 8'h28);
   endtask

   // ==========================================================
   // Main sequence and watchdog
   initial begin
      err_count = 0;
      num_checks = 0;
      rst_n = 1'b0;
      reg_addr = 12'h000;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_tx(1'b0, 1'b0, 1'b0, OFF_DATA_PORT0, 8'hA5);
      t_tx(1'b1, 1'b1, 1'b1, OFF_DATA_PORT1, 8'h5A);
      t_tx(1'b0, 1'b1, 1'b0, OFF_DATA_PORT0, 8'hC3);
      t_ir();
      t_rx();
      t_multi(2'b00, 4'b1111);
      t_multi(2'b01, 4'b1010);
      t_multi(2'b10, 4'b1100);
      t_multi(2'b11, 4'b0100);
      t_timer();
      close_out();
   end
   initial begin
      #200us;
      err_count++;
      close_out();
   end
endmodule
